// ==== rtl/cpi_top.sv ====
// Overview of operation
// - eight-bit pixel input with syncs
// - input up to 4096 wide, 2048 square scaled
// - preview output capped at 640x480
// - pixel clock, frame, line polarity invertible
// - embedded codes mark active video bounds
// - status word follows FF 00 00 preamble
// - status word: one, F, V, H, protection
// - F selects field, V marks blanking
// - H zero start, one end
// - undefined two low bits ignored
// - two paths: RGB preview, YCbCr codec
// - each path separately disabled
// - bus and pixel clocks unrelated
// - four rotating buffers, three codec planes
// - codec words little endian, earliest low
// - preview 24-bit one, 16-bit two per word
// - commands apply at frame sync fall
// - frame event precedes capture of frame
// - last frame enable clears when applied
// - frame counter steps 0..3 per event
// - codec overflow flagged when preview alone
// - software reset at global bit 31
// - format bit 31: 0 embedded, 1 separate
//
// Local design decisions: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module cpi_top #(
    parameter int MCLK_DIV = cpi_pkg::MCLK_DIV
) (
    // system
    input wire logic aclk,
    input wire logic aresetn,
    // register bus
    input wire logic [cpi_pkg::ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [cpi_pkg::ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // camera pins
    input wire logic sensor_pixel_clock,
    input wire logic frame_sync_in,
    input wire logic line_valid_in,
    input wire logic [7:0] pixel_data_in,
    output logic sensor_master_clock,
    output logic sensor_reset_out,
    // codec write stream
    output logic [31:0] codec_word,
    output logic [1:0] codec_plane,
    output logic [1:0] codec_buffer,
    output logic codec_valid,
    // preview write stream
    output logic [31:0] preview_word,
    output logic [1:0] preview_buffer,
    output logic preview_valid,
    // frame events
    output logic frame_irq,
    output logic last_frame_irq
);
    function automatic logic [31:0] wmask(input logic [31:0] old,
        input logic [31:0] nw, input logic [3:0] st);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
            if (st[i])
                r[8*i+:8] = nw[8*i+:8];
        return r;
    endfunction : wmask

    logic [31:0] src_fmt, glb_ctrl, cap_pend, cap_act, sta;
    logic [cpi_pkg::ADDR_W-1:0] aw_a;
    logic [31:0] w_d;
    logic [3:0] w_s;
    logic aw_have, w_have, do_wr, srst;
    logic wr_src, wr_win, wr_glb, wr_cap;
    logic ov_y, ov_cb, ov_cr;

    assign do_wr = aw_have && w_have && !bvalid;
    assign wr_src = do_wr && aw_a == cpi_pkg::OFS_SRC;
    assign wr_win = do_wr && aw_a == cpi_pkg::OFS_WIN;
    assign wr_glb = do_wr && aw_a == cpi_pkg::OFS_GLB;
    assign wr_cap = do_wr && aw_a == cpi_pkg::OFS_CAP;
    // soft reset holds the capture logic while set
    assign srst = !aresetn || glb_ctrl[cpi_pkg::B_SOFT_RESET_BIT];

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_have <= 1'b0;
            w_have <= 1'b0;
            awready <= 1'b0;
            wready <= 1'b0;
            bvalid <= 1'b0;
            bresp <= cpi_pkg::RESP_OK;
            aw_a <= '0;
            w_d <= '0;
            w_s <= '0;
        end
        else
        begin
            awready <= !aw_have && !(awvalid && awready) && !bvalid;
            wready <= !w_have && !(wvalid && wready) && !bvalid;
            if (awvalid && awready)
            begin
                aw_have <= 1'b1;
                aw_a <= awaddr;
            end
            if (wvalid && wready)
            begin
                w_have <= 1'b1;
                w_d <= wdata;
                w_s <= wstrb;
            end
            if (do_wr)
            begin
                aw_have <= 1'b0;
                w_have <= 1'b0;
                bvalid <= 1'b1;
                bresp <= (aw_a > cpi_pkg::OFS_CAP || aw_a[1:0] != 2'h0)
                    ? cpi_pkg::RESP_ERR : cpi_pkg::RESP_OK;
            end
            else if (bvalid && bready)
                bvalid <= 1'b0;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            arready <= 1'b0;
            rvalid <= 1'b0;
            rdata <= '0;
            rresp <= cpi_pkg::RESP_OK;
        end
        else
        begin
            arready <= !rvalid && !(arvalid && arready);
            if (arvalid && arready)
            begin
                rvalid <= 1'b1;
                rresp <= cpi_pkg::RESP_OK;
                unique case (araddr)
                    cpi_pkg::OFS_SRC: rdata <= src_fmt;
                    cpi_pkg::OFS_WIN: rdata <= '0;
                    cpi_pkg::OFS_GLB: rdata <= glb_ctrl;
                    cpi_pkg::OFS_CAP: rdata <= cap_pend;
                    cpi_pkg::OFS_STA: rdata <= sta;
                    default:
                    begin
                        rdata <= '0;
                        rresp <= cpi_pkg::RESP_ERR;
                    end
                endcase
            end
            else if (rvalid && rready)
                rvalid <= 1'b0;
        end
    end

    logic fs_fall, fs_rise, fs_lvl, in_frame;
    logic [1:0] fidx;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            src_fmt <= cpi_pkg::RST_SRC;
            glb_ctrl <= cpi_pkg::RST_GLB;
        end
        else
        begin
            if (wr_src)
                src_fmt <= wmask(src_fmt, w_d, w_s);
            if (wr_glb)
                glb_ctrl <= wmask(glb_ctrl, w_d, w_s) | cpi_pkg::RST_GLB;
        end
    end

    // enables wait here until the next frame start
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            cap_pend <= cpi_pkg::RST_CAP;
        else if (wr_cap)
            cap_pend <= wmask(cap_pend, w_d, w_s);
        else if (fs_fall)
            cap_pend[cpi_pkg::B_LAST] <= 1'b0;
    end

    assign sta = {ov_y, ov_cb, ov_cr, fs_lvl, fidx, in_frame, 25'h0};

    // pin synchronisers; pixel clock is sampled like data
    logic [10:0] s1, s2;
    logic pck_d, pe;
    logic [7:0] pd;
    // keeps sampling through soft reset so its release shows no false edge
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s1 <= '0;
            s2 <= '0;
            pck_d <= 1'b0;
        end
        else
        begin
            s1 <= {sensor_pixel_clock, frame_sync_in, line_valid_in, pixel_data_in};
            s2 <= s1;
            pck_d <= s2[10] ^ glb_ctrl[cpi_pkg::B_INV_PCLK];
        end
    end
    // needs the bus clock well above the pixel rate to see every edge
    assign pe = (s2[10] ^ glb_ctrl[cpi_pkg::B_INV_PCLK]) && !pck_d;
    assign pd = s2[7:0];

    logic sel601, fs601, lv601;
    assign sel601 = src_fmt[cpi_pkg::B_FMT601];
    assign fs601 = s2[9] ^ glb_ctrl[cpi_pkg::B_INV_FS];
    assign lv601 = s2[8] ^ glb_ctrl[cpi_pkg::B_INV_LV];

    // embedded sync decoding
    logic [23:0] hist;
    logic code_hit, prot_ok, f_flag, v_flag, lv656;
    // pins carry the upper eight of ten bits, so the undefined pair never arrives
    assign prot_ok = pd[3:0] == {pd[5] ^ pd[4], pd[6] ^ pd[4], pd[6] ^ pd[5],
        pd[6] ^ pd[5] ^ pd[4]};
    assign code_hit = pe && hist == {cpi_pkg::PRE_HI, cpi_pkg::PRE_LO,
        cpi_pkg::PRE_LO} && pd[7] && prot_ok;
    always_ff @(posedge aclk)
    begin
        if (srst)
        begin
            hist <= '0;
            f_flag <= 1'b0;
            v_flag <= 1'b1;
            lv656 <= 1'b0;
        end
        else if (pe)
        begin
            hist <= {hist[15:0], pd};
            if (code_hit)
            begin
                f_flag <= pd[6];
                v_flag <= pd[5];
                lv656 <= !pd[4] && !pd[5];
            end
        end
    end

    logic lv, lv_d, fs_d;
    assign fs_lvl = sel601 ? fs601 : v_flag;
    assign lv = sel601 ? lv601 : lv656;
    assign fs_fall = fs_d && !fs_lvl;
    assign fs_rise = !fs_d && fs_lvl;

    // frame start: apply commands; with global enable pending, raise event and step counter
    logic [1:0] bidx;
    always_ff @(posedge aclk)
    begin
        if (srst)
        begin
            // tracks the level so leaving soft reset is not a frame start
            fs_d <= fs_lvl;
            cap_act <= cpi_pkg::RST_CAP;
            fidx <= 2'h0;
            bidx <= 2'h0;
            in_frame <= 1'b0;
            frame_irq <= 1'b0;
            last_frame_irq <= 1'b0;
        end
        else
        begin
            fs_d <= fs_lvl;
            frame_irq <= 1'b0;
            last_frame_irq <= 1'b0;
            if (fs_fall)
            begin
                cap_act <= cap_pend;
                in_frame <= 1'b1;
                if (cap_pend[cpi_pkg::B_EN_G])
                begin
                    frame_irq <= 1'b1;
                    bidx <= fidx;
                    fidx <= fidx + 2'h1;
                end
            end
            else if (fs_rise)
            begin
                in_frame <= 1'b0;
                if (cap_act[cpi_pkg::B_LAST] && cap_act[cpi_pkg::B_EN_G])
                    last_frame_irq <= 1'b1;
            end
        end
    end

    // byte stream: phase, column and line counting
    logic [1:0] ph;
    logic [13:0] col;
    logic [12:0] ln;
    logic bv, by, bcb, en_c, en_p, col_ok;
    assign col_ok = cap_act[cpi_pkg::B_SCALE]
        ? (col < 14'(2 * cpi_pkg::MAX_SC) && ln < 13'(cpi_pkg::MAX_SC))
        : (col < 14'(2 * cpi_pkg::MAX_IN));
    assign bv = pe && in_frame && lv && cap_act[cpi_pkg::B_EN_G] && col_ok
        && (sel601 || (pd != cpi_pkg::PRE_HI && pd != cpi_pkg::PRE_LO))
        // status word after the preamble is timing, never a pixel
        && (sel601 || hist != {cpi_pkg::PRE_HI, cpi_pkg::PRE_LO, cpi_pkg::PRE_LO});
    assign by = ph[0] == !sel601;
    assign bcb = ph == (sel601 ? 2'h1 : 2'h0);
    assign en_c = cap_act[cpi_pkg::B_EN_C];
    assign en_p = cap_act[cpi_pkg::B_EN_P];
    always_ff @(posedge aclk)
    begin
        if (srst || fs_fall)
        begin
            ph <= 2'h0;
            col <= '0;
            ln <= '0;
            lv_d <= 1'b0;
        end
        else
        begin
            lv_d <= lv;
            if (lv && !lv_d)
            begin
                ph <= 2'h0;
                col <= '0;
            end
            else if (bv)
            begin
                ph <= ph + 2'h1;
                col <= col + 14'h1;
            end
            if (!lv && lv_d && ln < 13'(cpi_pkg::MAX_IN))
                ln <= ln + 13'h1;
        end
    end

    // codec packing per plane, earliest byte lowest
    logic [31:0] y_sh, cb_sh, cr_sh;
    logic [1:0] y_n, cb_n, cr_n;
    logic c_ok;
    assign c_ok = cap_act[cpi_pkg::B_C422] || !ln[0];
    always_ff @(posedge aclk)
    begin
        if (srst || fs_fall)
        begin
            y_sh <= '0;
            cb_sh <= '0;
            cr_sh <= '0;
            y_n <= 2'h0;
            cb_n <= 2'h0;
            cr_n <= 2'h0;
            codec_valid <= 1'b0;
            codec_word <= '0;
            codec_plane <= 2'(cpi_pkg::PL_Y);
            codec_buffer <= 2'h0;
        end
        else
        begin
            codec_valid <= 1'b0;
            codec_buffer <= bidx;
            if (bv && en_c && by)
            begin
                y_sh <= {pd, y_sh[31:8]};
                y_n <= y_n + 2'h1;
                if (y_n == 2'h3)
                begin
                    codec_word <= {pd, y_sh[31:8]};
                    codec_plane <= 2'(cpi_pkg::PL_Y);
                    codec_valid <= 1'b1;
                end
            end
            else if (bv && en_c && c_ok && bcb)
            begin
                cb_sh <= {pd, cb_sh[31:8]};
                cb_n <= cb_n + 2'h1;
                if (cb_n == 2'h3)
                begin
                    codec_word <= {pd, cb_sh[31:8]};
                    codec_plane <= 2'(cpi_pkg::PL_CB);
                    codec_valid <= 1'b1;
                end
            end
            else if (bv && en_c && c_ok)
            begin
                cr_sh <= {pd, cr_sh[31:8]};
                cr_n <= cr_n + 2'h1;
                if (cr_n == 2'h3)
                begin
                    codec_word <= {pd, cr_sh[31:8]};
                    codec_plane <= 2'(cpi_pkg::PL_CR);
                    codec_valid <= 1'b1;
                end
            end
        end
    end

    // codec input fills unread while preview runs alone; set beats clear
    logic ovf_ev;
    assign ovf_ev = bv && en_p && !en_c;
    always_ff @(posedge aclk)
    begin
        if (srst)
        begin
            ov_y <= 1'b0;
            ov_cb <= 1'b0;
            ov_cr <= 1'b0;
        end
        else
        begin
            if (ovf_ev && by)
                ov_y <= 1'b1;
            else if (wr_win && w_d[cpi_pkg::B_CLR_Y])
                ov_y <= 1'b0;
            if (ovf_ev && !by && bcb)
                ov_cb <= 1'b1;
            else if (wr_win && w_d[cpi_pkg::B_CLR_CB])
                ov_cb <= 1'b0;
            if (ovf_ev && !by && !bcb)
                ov_cr <= 1'b1;
            else if (wr_win && w_d[cpi_pkg::B_CLR_CR])
                ov_cr <= 1'b0;
        end
    end

    // preview: luma-only RGB, no colour matrix
    logic p_ok, p_half;
    logic [15:0] p_lo, rgb16;
    assign p_ok = bv && en_p && by && col < 14'(2 * cpi_pkg::PRV_W)
        && ln < 13'(cpi_pkg::PRV_H);
    assign rgb16 = {pd[7:3], pd[7:2], pd[7:3]};
    always_ff @(posedge aclk)
    begin
        if (srst || fs_fall)
        begin
            p_half <= 1'b0;
            p_lo <= '0;
            preview_valid <= 1'b0;
            preview_word <= '0;
            preview_buffer <= 2'h0;
        end
        else
        begin
            preview_valid <= 1'b0;
            preview_buffer <= bidx;
            if (lv && !lv_d)
                p_half <= 1'b0;
            else if (p_ok && cap_act[cpi_pkg::B_RGB24])
            begin
                preview_word <= {8'h00, pd, pd, pd};
                preview_valid <= 1'b1;
            end
            else if (p_ok)
            begin
                p_half <= !p_half;
                p_lo <= rgb16;
                if (p_half)
                begin
                    preview_word <= {rgb16, p_lo};
                    preview_valid <= 1'b1;
                end
            end
        end
    end

    // master clock to the camera by toggle divider
    logic [7:0] mdiv;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            mdiv <= '0;
            sensor_master_clock <= 1'b0;
            sensor_reset_out <= 1'b0;
        end
        else
        begin
            sensor_reset_out <= glb_ctrl[cpi_pkg::B_CAMRST];
            if (mdiv == 8'(MCLK_DIV / 2 - 1))
            begin
                mdiv <= '0;
                sensor_master_clock <= !sensor_master_clock;
            end
            else
                mdiv <= mdiv + 8'h1;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (srst);
    property p_irq_fall;
        frame_irq |-> $past(fs_fall) && $past(cap_pend[cpi_pkg::B_EN_G]);
    endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("irq not at fs fall");
    property p_cnt;
        frame_irq |-> fidx == $past(fidx) + 2'h1 && bidx == $past(fidx);
    endproperty
    a_cnt: assert property (p_cnt) else $error("frame count bad");
    property p_last_clr;
        fs_fall && !wr_cap |=> !cap_pend[cpi_pkg::B_LAST];
    endproperty
    a_last_clr: assert property (p_last_clr) else $error("last en kept");
    property p_hold;
        !fs_fall |=> $stable(cap_act);
    endproperty
    a_hold: assert property (p_hold) else $error("config changed midframe");
    property p_ovf;
        ovf_ev && by |=> ov_y;
    endproperty
    a_ovf: assert property (p_ovf) else $error("overflow lost");
    property p_prv;
        preview_valid |-> $past(ln) < 13'(cpi_pkg::PRV_H) && $past(en_p);
    endproperty
    a_prv: assert property (p_prv) else $error("preview out of window");
    sequence s_sav;
        code_hit && !pd[4] && !pd[5];
    endsequence
    property p_sav;
        s_sav |=> lv656;
    endproperty
    a_sav: assert property (p_sav) else $error("sav missed");
    property p_le;
        codec_valid |-> codec_word[31:24] == $past(pd) && $past(en_c);
    endproperty
    a_le: assert property (p_le) else $error("codec byte order");
endmodule : cpi_top
`default_nettype wire

// ==== rtl/cpi_pkg.sv ====
package cpi_pkg;
    // register byte offsets
    localparam int ADDR_W = 5;
    localparam logic [4:0] OFS_SRC = 5'h00;
    localparam logic [4:0] OFS_WIN = 5'h04;
    localparam logic [4:0] OFS_GLB = 5'h08;
    localparam logic [4:0] OFS_CAP = 5'h0C;
    localparam logic [4:0] OFS_STA = 5'h10;
    // source format fields
    localparam int B_FMT601 = 31;
    // window register: overflow clears
    localparam int B_CLR_Y = 30;
    localparam int B_CLR_CB = 15;
    localparam int B_CLR_CR = 14;
    // global control fields
    localparam int B_SOFT_RESET_BIT = 31;
    localparam int B_CAMRST = 30;
    localparam int B_INV_PCLK = 26;
    localparam int B_INV_FS = 25;
    localparam int B_INV_LV = 24;
    // capture control fields
    localparam int B_EN_G = 31;
    localparam int B_EN_C = 30;
    localparam int B_EN_P = 29;
    localparam int B_LAST = 28;
    localparam int B_RGB24 = 27;
    localparam int B_C422 = 26;
    localparam int B_SCALE = 25;
    // status fields
    localparam int B_OV_Y = 31;
    localparam int B_OV_CB = 30;
    localparam int B_OV_CR = 29;
    localparam int B_FS_LVL = 28;
    localparam int B_FIDX = 26;
    localparam int B_INFRM = 25;
    // reset values
    localparam logic [31:0] RST_SRC = 32'h0000_0000;
    localparam logic [31:0] RST_GLB = 32'h2000_0000;
    localparam logic [31:0] RST_CAP = 32'h0000_0000;
    // embedded sync preamble
    localparam logic [7:0] PRE_HI = 8'hFF;
    localparam logic [7:0] PRE_LO = 8'h00;
    // image limits
    localparam int MAX_IN = 4096;
    localparam int MAX_SC = 2048;
    localparam int PRV_W = 640;
    localparam int PRV_H = 480;
    localparam int MCLK_DIV = 4;
    localparam logic [1:0] RESP_OK = 2'h0;
    localparam logic [1:0] RESP_ERR = 2'h2;
    typedef enum logic [1:0] {PL_Y, PL_CB, PL_CR} cpi_plane_e;
endpackage : cpi_pkg

// ==== verif/cpi_cam_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module cpi_cam_model (
    // camera pins
    output logic pclk,
    output logic fs,
    output logic lv,
    output logic [7:0] pd
);
    logic [7:0] last;
    initial
    begin
        pclk = 1'b0;
        fs = 1'b1;
        lv = 1'b0;
        pd = 8'hA5;
        last = 8'hA5;
    end
    // 80 ns per byte, far slower than the bus clock; clock runs only while bytes are put and stands still between lines
    task automatic put(input logic [7:0] b);
        pd = b;
        last = b;
        #20 pclk = 1'b1;
        #40 pclk = 1'b0;
        #20 pd = ~last;
    endtask : put
    // field 0 only; protection bits follow from v and h
    task automatic code(input logic v, input logic h);
        put(8'hFF);
        put(8'h00);
        put(8'h00);
        put({2'b10, v, h, v ^ h, h, v, v ^ h});
    endtask : code
    task automatic frame(input logic emb, input logic act, input int lines);
        int l;
        int k;
        if (!emb) fs = act;
        #400;
        if (emb) code(1'b1, 1'b1);
        for (l = 0; l < lines; l++)
        begin
            if (emb) code(1'b0, 1'b0);
            else lv = 1'b1;
            for (k = 0; k < 16; k++) put(8'h10 + 8'(k));
            if (emb) code(1'b0, 1'b1);
            else lv = 1'b0;
            #200;
        end
        if (emb) code(1'b1, 1'b1);
        else fs = ~act;
        #400;
    endtask : frame
    task automatic idle(input logic lvl);
        fs = lvl;
    endtask : idle
endmodule : cpi_cam_model
`default_nettype wire

// ==== verif/cpi_top_bench.sv ====
`timescale 1ns/1ns
`default_nettype none
module cpi_top_bench;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [4:0] awaddr = 5'h00, araddr = 5'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic awready, wready, arready, bvalid, rvalid, codec_valid, preview_valid;
    logic frame_irq, last_frame_irq, pclk, fs, lv, mclk, cam_rst, mc;
    logic [1:0] bresp, rresp, codec_plane, codec_buffer, preview_buffer, cbuf;
    logic [31:0] rdata, codec_word, preview_word;
    logic [7:0] pd;
    logic [31:0] yq[$], bq[$], rq[$], pq[$];
    int miscompares = 0, checks_done = 0, n_irq = 0, n_last = 0, early = 0;
    localparam logic [1:0] OK = cpi_pkg::RESP_OK;

    always #5 aclk = ~aclk;

    cpi_top #(.MCLK_DIV(2)) cpi_top_inst (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .sensor_pixel_clock(pclk),
        .frame_sync_in(fs), .line_valid_in(lv), .pixel_data_in(pd),
        .sensor_master_clock(mclk), .sensor_reset_out(cam_rst), .codec_word(codec_word),
        .codec_plane(codec_plane), .codec_buffer(codec_buffer), .codec_valid(codec_valid),
        .preview_word(preview_word), .preview_buffer(preview_buffer),
        .preview_valid(preview_valid), .frame_irq(frame_irq), .last_frame_irq(last_frame_irq));

    cpi_cam_model cam_inst (.pclk(pclk), .fs(fs), .lv(lv), .pd(pd));

    always @(posedge aclk)
    begin
        if (codec_valid === 1'b1)
        begin
            if (n_irq == 0) early++;
            cbuf = codec_buffer;
            if (codec_plane === 2'h0) yq.push_back(codec_word);
            else if (codec_plane === 2'h1) bq.push_back(codec_word);
            else rq.push_back(codec_word);
        end
        if (preview_valid === 1'b1) pq.push_back(preview_word);
        if (frame_irq === 1'b1) n_irq++;
        if (last_frame_irq === 1'b1) n_last++;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic complete_run;
        $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : complete_run

    task automatic wr(input logic [4:0] a, input logic [31:0] v, input logic [1:0] er);
        awaddr <= a;
        wdata <= v;
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end
        while (bvalid !== 1'b1);
        bready <= 1'b0;
        check(32'(bresp), 32'(er));
    endtask : wr

    task automatic rd(input logic [4:0] a, input logic [31:0] m, input logic [31:0] ev,
                      input logic [1:0] er);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
        end
        while (rvalid !== 1'b1);
        rready <= 1'b0;
        check(rdata & m, ev);
        check(32'(rresp), 32'(er));
    endtask : rd

    // clears the stream queues, then one frame of 16-byte lines
    task automatic run(input logic emb, input logic act, input int lines);
        yq.delete();
        bq.delete();
        rq.delete();
        pq.delete();
        n_irq = 0;
        n_last = 0;
        cam_inst.frame(emb, act, lines);
        repeat (10) @(posedge aclk);
    endtask : run

    function automatic logic [31:0] w4(input logic [7:0] b, input logic [7:0] s);
        return {8'(b + 3 * s), 8'(b + 2 * s), 8'(b + s), b};
    endfunction : w4

    function automatic logic [15:0] g(input logic [7:0] y);
        return {y[7:3], y[7:2], y[7:3]};
    endfunction : g

    initial
    begin
        repeat (20000) @(posedge aclk);
        miscompares++;
        complete_run();
    end

    initial
    begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        rd(cpi_pkg::OFS_GLB, 32'hFFFFFFFF, cpi_pkg::RST_GLB, OK);
        rd(cpi_pkg::OFS_CAP, 32'hFFFFFFFF, cpi_pkg::RST_CAP, OK);
        rd(5'h14, 32'hFFFFFFFF, 32'h0, cpi_pkg::RESP_ERR);
        wr(5'h14, 32'hFFFFFFFF, cpi_pkg::RESP_ERR);
        wr(cpi_pkg::OFS_SRC, 32'hFFFFFFFF, OK);
        rd(cpi_pkg::OFS_SRC, 32'hFFFFFFFF, 32'hFFFFFFFF, OK);
        wr(cpi_pkg::OFS_SRC, 32'h80000000, OK);
        rd(cpi_pkg::OFS_WIN, 32'hFFFFFFFF, 32'h0, OK);
        wr(cpi_pkg::OFS_GLB, 32'h60000000, OK);
        @(posedge aclk);
        check(32'(cam_rst), 32'h1);
        mc = mclk;
        @(posedge aclk);
        check(32'(mclk ^ mc), 32'h1);
        wr(cpi_pkg::OFS_GLB, cpi_pkg::RST_GLB, OK);
        $display("test registers finished");
        wr(cpi_pkg::OFS_CAP, 32'hEC000000, OK);
        fork
            run(1'b0, 1'b0, 1);
            begin
                repeat (30) @(posedge aclk);
                wr(cpi_pkg::OFS_CAP, 32'hA0000000, OK);
            end
        join
        check(32'(yq.size()), 32'h2);
        check(yq[0], w4(8'h10, 8'h2));
        check(yq[1], w4(8'h18, 8'h2));
        check(bq[0], w4(8'h11, 8'h4));
        check(rq[0], w4(8'h13, 8'h4));
        check(32'(pq.size()), 32'h8);
        check(pq[7], 32'h001E1E1E);
        check(32'(early), 32'h0);
        check(32'(cbuf), 32'h0);
        rd(cpi_pkg::OFS_STA, 32'h1C000000, 32'h14000000, OK);
        $display("test both paths finished");
        run(1'b0, 1'b0, 1);
        check(32'(yq.size() + bq.size() + rq.size()), 32'h0);
        check(32'(pq.size()), 32'h4);
        check(pq[0], {g(8'h12), g(8'h10)});
        rd(cpi_pkg::OFS_STA, 32'hE0000000, 32'hE0000000, OK);
        wr(cpi_pkg::OFS_WIN, 32'h40000000, OK);
        rd(cpi_pkg::OFS_STA, 32'hE0000000, 32'h60000000, OK);
        $display("test preview only finished");
        wr(cpi_pkg::OFS_CAP, 32'hD0000000, OK);
        run(1'b0, 1'b0, 2);
        check(32'(yq.size()), 32'h4);
        check(yq[2], w4(8'h10, 8'h2));
        check(32'(bq.size() + rq.size()), 32'h2);
        check(32'(n_last), 32'h1);
        check(32'(cbuf), 32'h2);
        rd(cpi_pkg::OFS_CAP, 32'hFFFFFFFF, 32'hC0000000, OK);
        rd(cpi_pkg::OFS_STA, 32'h0C000000, 32'h0C000000, OK);
        $display("test last frame finished");
        wr(cpi_pkg::OFS_GLB, 32'hA2000000, OK);
        cam_inst.idle(1'b0);
        wr(cpi_pkg::OFS_GLB, 32'h22000000, OK);
        rd(cpi_pkg::OFS_STA, 32'hEC000000, 32'h0, OK);
        for (int k = 1; k <= 4; k++)
        begin
            run(1'b0, 1'b1, 1);
            check(32'(n_irq), 32'h1);
            check(32'(yq.size()), 32'h2);
            rd(cpi_pkg::OFS_STA, 32'h0C000000, 32'(k % 4) << 26, OK);
        end
        $display("test inverted sync finished");
        wr(cpi_pkg::OFS_SRC, 32'h0, OK);
        cam_inst.idle(1'b1);
        wr(cpi_pkg::OFS_GLB, cpi_pkg::RST_GLB, OK);
        wr(cpi_pkg::OFS_CAP, 32'hC4000000, OK);
        run(1'b1, 1'b0, 1);
        check(32'(n_irq), 32'h1);
        check(yq[0], w4(8'h11, 8'h2));
        check(yq[1], w4(8'h19, 8'h2));
        check(bq[0], w4(8'h10, 8'h4));
        check(rq[0], w4(8'h12, 8'h4));
        $display("test embedded sync finished");
        complete_run();
    end
endmodule : cpi_top_bench
`default_nettype wire
